/* core/inband_pkg.sv */
// constants shared by the in-band loop code engine files
// assumes a 32-bit apb slave, one register per aligned word (byte address = index * 4)
package inband_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_CTRL       = 8'hB4; // insert enable and detector status
	localparam logic [7:0] IDX_LENGTHS    = 8'hB6; // code length selects
	localparam logic [7:0] IDX_TX_HI      = 8'hB7;
	localparam logic [7:0] IDX_TX_LO      = 8'hB8;
	localparam logic [7:0] IDX_UP_HI      = 8'hB9;
	localparam logic [7:0] IDX_UP_LO      = 8'hBA;
	localparam logic [7:0] IDX_DOWN_HI    = 8'hBB;
	localparam logic [7:0] IDX_DOWN_LO    = 8'hBC;
	localparam logic [7:0] IDX_SPARE_CTRL = 8'hBD;
	localparam logic [7:0] IDX_SPARE_HI   = 8'hBE;
	localparam logic [7:0] IDX_SPARE_LO   = 8'hBF;

	// ==========================================================
	// reset values and field positions
	localparam logic [7:0] REG_RESET     = 8'h00; // every register clears to zero
	localparam int         TX_SEL_LSB    = 6;     // tx length select, bits 7:6
	localparam int         UP_SEL_LSB    = 3;     // up-code length select, bits 5:3
	localparam int         DOWN_SEL_LSB  = 0;     // down-code length select, bits 2:0
	localparam int         SPARE_SEL_LSB = 0;     // spare length select, bits 2:0
	localparam int         CTRL_INSERT   = 0;     // code insertion enable
	localparam int         STAT_UP       = 4;     // up-code detected
	localparam int         STAT_DOWN     = 5;     // down-code detected
	localparam int         STAT_SPARE    = 6;     // spare code detected

	// ==========================================================
	// lengths and timing
	localparam logic [4:0]  LEN_16         = 5'd16; // longest pattern
	localparam logic [15:0] INTEG_BITS_DEF = 16'd1000; // line bits of steady match

	// tx select: 00 five, 01 six (three twice), 10 seven, 11 sixteen
	function automatic logic [4:0] tx_len_of(input logic [1:0] sel);
		unique case (sel)
			2'b00: tx_len_of = 5'd5;
			2'b01: tx_len_of = 5'd6;
			2'b10: tx_len_of = 5'd7;
			2'b11: tx_len_of = LEN_16;
		endcase
	endfunction

	// rx select: value plus one, all ones means sixteen (eight twice)
	function automatic logic [4:0] rx_len_of(input logic [2:0] sel);
		rx_len_of = (sel == 3'b111) ? LEN_16 : ({2'b00, sel} + 5'd1);
	endfunction

endpackage

/* core/code_detector.sv */
// one repeating-code detector with an integration counter
// assumes bit_in qualified by bit_strobe from same-clock framer logic
`timescale 1ns/100ps
module code_detector
	import inband_pkg::*;
#(
	parameter logic [15:0] INTEG_BITS = INTEG_BITS_DEF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        bit_strobe,
	input  wire logic        bit_in,
	input  wire logic [7:0]  pat_hi,
	input  wire logic [7:0]  pat_lo,
	input  wire logic [4:0]  len,
	input  wire logic        restart,
	output logic             detected
);

	// ==========================================================
	// comparison window
	logic [15:0] hist;      // last sixteen bits, newest in bit 0
	logic [15:0] next_hist; // window including the arriving bit
	logic [16:0] ones;      // length-wide run of ones
	logic [15:0] expect_w;  // pattern right-aligned to the window
	logic        aligned;   // newest len bits of the window equal the pattern
	logic        period_ok; // arriving bit repeats the one len bits ago
	logic        locked;    // pattern phase found
	logic [15:0] count;     // line bits of steady match

	always_comb begin
		next_hist = {hist[14:0], bit_in};
		ones      = (17'h00001 << len) - 17'h00001;
		// short lengths use only the top bits of the high byte
		if (len == LEN_16) begin
			expect_w = {pat_hi, pat_lo};
		end else begin
			expect_w = {8'h00, pat_hi} >> (5'd8 - len);
		end
		aligned   = ((next_hist ^ expect_w) & ones[15:0]) == 16'h0000;
		period_ok = bit_in == hist[4'(len - 5'd1)];
	end

	// window shift
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist <= 16'h0000;
		end else if (bit_strobe) begin
			hist <= next_hist;
		end
	end

	// lock and integration; any break starts the period again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			locked <= 1'b0;
			count  <= 16'h0000;
		end else if (restart) begin
			locked <= 1'b0;
			count  <= 16'h0000;
		end else if (bit_strobe) begin
			if (locked && period_ok) begin
				count <= (count == INTEG_BITS) ? count : count + 16'h0001;
			end else begin
				// a mismatch may still be the start of a fresh alignment
				locked <= aligned;
				count  <= 16'h0000;
			end
		end
	end

	// declared only once the whole period has matched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			detected <= 1'b0;
		end else begin
			detected <= locked && (count == INTEG_BITS) && !restart;
		end
	end

endmodule

/* core/tx_pattern_gen.sv */
// repeating transmit code generator, msb of the high byte goes first
// assumes data_in and bit_strobe come from same-clock framer logic
`timescale 1ns/100ps
module tx_pattern_gen
	import inband_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        bit_strobe,
	input  wire logic        insert_en,
	input  wire logic        data_in,
	input  wire logic [15:0] pattern,
	input  wire logic [4:0]  len,
	output logic             data_out,
	output logic [3:0]       phase
);

	// ==========================================================
	// phase walks 0..len-1; a shorter len taken mid-pattern wraps at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 4'h0;
		end else if (!insert_en) begin
			phase <= 4'h0;
		end else if (bit_strobe) begin
			if ({1'b0, phase} + 5'd1 >= len) begin
				phase <= 4'h0;
			end else begin
				phase <= phase + 4'h1;
			end
		end
	end

	// line bit: pattern while inserting, else the framer's data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_out <= 1'b0;
		end else if (bit_strobe) begin
			data_out <= insert_en ? pattern[4'hF - phase] : data_in;
		end
	end

endmodule

/* core/inband_loop_code_engine.sv */
// in-band loop code engine: apb registers, one generator, three detectors
// assumes line bits and strobes arrive from framer logic on pclk
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
module inband_loop_code_engine
	import inband_pkg::*;
#(
	parameter logic [15:0] INTEG_BITS = INTEG_BITS_DEF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        tx_bit_strobe,
	input  wire logic        tx_data_in,
	output logic             tx_data_out,
	input  wire logic        rx_bit_strobe,
	input  wire logic        rx_data_in,
	output logic             up_detected,
	output logic             down_detected,
	output logic             spare_detected
);

	// ==========================================================
	// registers
	logic [7:0] engine_ctrl;          // insert enable in bit 0
	logic [7:0] inband_code_lengths;  // tx, up and down length selects
	logic [7:0] tx_pattern_high;
	logic [7:0] tx_pattern_low;
	logic [7:0] rx_up_pattern_high;
	logic [7:0] rx_up_pattern_low;
	logic [7:0] rx_down_pattern_high;
	logic [7:0] rx_down_pattern_low;
	logic [7:0] spare_code_control;
	logic [7:0] spare_pattern_high;
	logic [7:0] spare_pattern_low;

	// ==========================================================
	// bus decode
	logic [7:0] index;      // word index of the access
	logic       hit;        // address maps to a register: index is mapped and paddr[11:10] are zero
	logic [7:0] read_byte;  // addressed register contents
	logic       access;     // access phase of a transfer
	logic       wr_en;      // write takes effect this edge
	logic [1:0] tx_length_sel;
	logic [2:0] up_length_sel;
	logic [2:0] down_length_sel;
	logic [2:0] spare_length_sel;
	logic [4:0] tx_len;
	logic [4:0] up_len;
	logic [4:0] down_len;
	logic [4:0] spare_len;
	logic [3:0] tx_phase;   // generator position in the pattern
	logic       up_restart;
	logic       down_restart;
	logic       spare_restart;

	assign index  = paddr[9:2];
	assign access = psel && penable;
	// the slave never stalls, so every access ends in one cycle
	assign pready = 1'b1;
	// unmapped words answer with an error and change nothing
	assign pslverr = access && !hit;
	// only the low lane carries register bits
	assign wr_en   = access && pwrite && hit && pstrb[0];

	// address decode and read mux
	always_comb begin
		hit       = (paddr[11:10] == 2'b00);
		read_byte = 8'h00;
		unique case (index)
			IDX_CTRL: begin
				read_byte              = engine_ctrl;
				read_byte[STAT_UP]     = up_detected;
				read_byte[STAT_DOWN]   = down_detected;
				read_byte[STAT_SPARE]  = spare_detected;
			end
			IDX_LENGTHS:    read_byte = inband_code_lengths;
			IDX_TX_HI:      read_byte = tx_pattern_high;
			IDX_TX_LO:      read_byte = tx_pattern_low;
			IDX_UP_HI:      read_byte = rx_up_pattern_high;
			IDX_UP_LO:      read_byte = rx_up_pattern_low;
			IDX_DOWN_HI:    read_byte = rx_down_pattern_high;
			IDX_DOWN_LO:    read_byte = rx_down_pattern_low;
			IDX_SPARE_CTRL: read_byte = spare_code_control;
			IDX_SPARE_HI:   read_byte = spare_pattern_high;
			IDX_SPARE_LO:   read_byte = spare_pattern_low;
			default: begin
				// unmapped index
				hit = 1'b0;
			end
		endcase
	end

	// read data captured in the setup cycle, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= {24'h000000, read_byte};
		end
	end

	// ==========================================================
	// register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			engine_ctrl          <= REG_RESET;
			inband_code_lengths  <= REG_RESET;
			tx_pattern_high      <= REG_RESET;
			tx_pattern_low       <= REG_RESET;
			rx_up_pattern_high   <= REG_RESET;
			rx_up_pattern_low    <= REG_RESET;
			rx_down_pattern_high <= REG_RESET;
			rx_down_pattern_low  <= REG_RESET;
			spare_code_control   <= REG_RESET;
			spare_pattern_high   <= REG_RESET;
			spare_pattern_low    <= REG_RESET;
		end else if (wr_en) begin
			unique case (index)
				// status bits are live, so only the enable is stored
				IDX_CTRL:       engine_ctrl <= {7'h00, pwdata[CTRL_INSERT]};
				IDX_LENGTHS:    inband_code_lengths  <= pwdata[7:0];
				IDX_TX_HI:      tx_pattern_high      <= pwdata[7:0];
				IDX_TX_LO:      tx_pattern_low       <= pwdata[7:0];
				IDX_UP_HI:      rx_up_pattern_high   <= pwdata[7:0];
				IDX_UP_LO:      rx_up_pattern_low    <= pwdata[7:0];
				IDX_DOWN_HI:    rx_down_pattern_high <= pwdata[7:0];
				IDX_DOWN_LO:    rx_down_pattern_low  <= pwdata[7:0];
				// upper bits are stored as written; software keeps them zero
				IDX_SPARE_CTRL: spare_code_control   <= pwdata[7:0];
				IDX_SPARE_HI:   spare_pattern_high   <= pwdata[7:0];
				IDX_SPARE_LO:   spare_pattern_low    <= pwdata[7:0];
				default: begin
					// no register here
				end
			endcase
		end
	end

	// ==========================================================
	// length decode
	assign tx_length_sel    = inband_code_lengths[TX_SEL_LSB +: 2];
	assign up_length_sel    = inband_code_lengths[UP_SEL_LSB +: 3];
	assign down_length_sel  = inband_code_lengths[DOWN_SEL_LSB +: 3];
	assign spare_length_sel = spare_code_control[SPARE_SEL_LSB +: 3];
	assign tx_len    = tx_len_of(tx_length_sel);
	assign up_len    = rx_len_of(up_length_sel);
	assign down_len  = rx_len_of(down_length_sel);
	assign spare_len = rx_len_of(spare_length_sel);

	// writing a high pattern byte restarts that detector's period
	assign up_restart    = wr_en && (index == IDX_UP_HI);
	assign down_restart  = wr_en && (index == IDX_DOWN_HI);
	assign spare_restart = wr_en && (index == IDX_SPARE_HI);

	// ==========================================================
	// transmit generator; the low byte is only reached at sixteen bits
	tx_pattern_gen u_tx_gen (
		.pclk       (pclk),
		.presetn    (presetn),
		.bit_strobe (tx_bit_strobe),
		.insert_en  (engine_ctrl[CTRL_INSERT]),
		.data_in    (tx_data_in),
		.pattern    ({tx_pattern_high, tx_pattern_low}),
		.len        (tx_len),
		.data_out   (tx_data_out),
		.phase      (tx_phase)
	);

	// ==========================================================
	// receive detectors; high-byte bits past the length are masked off
	code_detector #(.INTEG_BITS(INTEG_BITS)) u_up_det (
		.pclk       (pclk),
		.presetn    (presetn),
		.bit_strobe (rx_bit_strobe),
		.bit_in     (rx_data_in),
		.pat_hi     (rx_up_pattern_high),
		.pat_lo     (rx_up_pattern_low),
		.len        (up_len),
		.restart    (up_restart),
		.detected   (up_detected)
	);

	code_detector #(.INTEG_BITS(INTEG_BITS)) u_down_det (
		.pclk       (pclk),
		.presetn    (presetn),
		.bit_strobe (rx_bit_strobe),
		.bit_in     (rx_data_in),
		.pat_hi     (rx_down_pattern_high),
		.pat_lo     (rx_down_pattern_low),
		.len        (down_len),
		.restart    (down_restart),
		.detected   (down_detected)
	);

	code_detector #(.INTEG_BITS(INTEG_BITS)) u_spare_det (
		.pclk       (pclk),
		.presetn    (presetn),
		.bit_strobe (rx_bit_strobe),
		.bit_in     (rx_data_in),
		.pat_hi     (spare_pattern_high),
		.pat_lo     (spare_pattern_low),
		.len        (spare_len),
		.restart    (spare_restart),
		.detected   (spare_detected)
	);

	// ==========================================================
	// checks
	a_tx_len_map: assert property (@(posedge pclk) disable iff (!presetn)
		tx_len == ((tx_length_sel == 2'b00) ? 5'd5 : (tx_length_sel == 2'b01) ? 5'd6 :
			(tx_length_sel == 2'b10) ? 5'd7 : 5'd16))
		else $error("tx length decode wrong");

	a_up_len_map: assert property (@(posedge pclk) disable iff (!presetn)
		(inband_code_lengths[5:3] == 3'b111) ? (up_len == 5'd16)
			: (up_len == {2'b00, inband_code_lengths[5:3]} + 5'd1))
		else $error("up length decode wrong");

	a_down_len_map: assert property (@(posedge pclk) disable iff (!presetn)
		(inband_code_lengths[2:0] == 3'b111) ? (down_len == 5'd16)
			: (down_len == {2'b00, inband_code_lengths[2:0]} + 5'd1))
		else $error("down length decode wrong");

	a_spare_len_map: assert property (@(posedge pclk) disable iff (!presetn)
		(spare_code_control[2:0] == 3'b111) ? (spare_len == 5'd16)
			: (spare_len == {2'b00, spare_code_control[2:0]} + 5'd1))
		else $error("spare length decode wrong");

	a_first_bit_out: assert property (@(posedge pclk) disable iff (!presetn)
		(engine_ctrl[0] && tx_bit_strobe && tx_phase == 4'h0)
			|=> (tx_data_out == $past(tx_pattern_high[7])))
		else $error("first sent bit is not high bit 7");

	a_phase_wraps: assert property (@(posedge pclk) disable iff (!presetn)
		(engine_ctrl[0] && tx_bit_strobe && {1'b0, tx_phase} == tx_len - 5'd1
			&& $stable(tx_len)) |=> (tx_phase == 4'h0))
		else $error("pattern does not repeat at its length");

	a_pass_through: assert property (@(posedge pclk) disable iff (!presetn)
		(!engine_ctrl[0] && tx_bit_strobe) |=> (tx_data_out == $past(tx_data_in)))
		else $error("line data not passed while idle");

	a_restart_clears: assert property (@(posedge pclk) disable iff (!presetn)
		up_restart |=> !up_detected [*2])
		else $error("up detector survives a pattern write");

	a_down_restart: assert property (@(posedge pclk) disable iff (!presetn)
		down_restart |=> !down_detected)
		else $error("down detector survives a pattern write");

	a_apb_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		(access && paddr[11:10] != 2'b00) |-> (pslverr && pready))
		else $error("unmapped access not refused");

	a_spare_restart: assert property (@(posedge pclk) disable iff (!presetn)
		spare_restart |=> !spare_detected)
		else $error("spare detector survives a pattern write");

	a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && index == IDX_LENGTHS) |=> (inband_code_lengths == $past(pwdata[7:0])))
		else $error("length write did not land");

	// ==========================================================
	// integration watch for the up detector
	// saturates, so a long steady code cannot wrap it back under the limit
	logic [16:0] up_seen; // line bits seen since the last restart

	// counts every received bit; a high pattern write starts it again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_seen <= 17'h00000;
		end else if (up_restart) begin
			up_seen <= 17'h00000;
		end else if (rx_bit_strobe && up_seen != 17'h1FFFF) begin
			up_seen <= up_seen + 17'h00001;
		end
	end

	// a declaration needs the aligning bits plus a whole period of matches
	a_up_integrated: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(up_detected) |-> (up_seen >= {12'h000, up_len} + {1'b0, INTEG_BITS}))
		else $error("up code declared before a full integration");

endmodule

/* dv/line_partner.sv */
// far-end line model: makes the bit strobes, plays a code, records tx bits
// assumes pclk is the line clock and presetn is active low
`timescale 1ns/100ps
module line_partner (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        run,
	input  wire logic        slow,
	input  wire logic        clr,
	input  wire logic [15:0] rx_pat,
	input  wire logic [4:0]  rx_len,
	input  wire logic        tx_data_out,
	output logic             tx_bit_strobe,
	output logic             tx_data_in,
	output logic             rx_bit_strobe,
	output logic             rx_data_in,
	output logic [15:0]      tx_cap,
	output logic [15:0]      bit_count
);
	// ==========================================================
	// strobe timing
	logic [1:0] gap_cnt; // spaces strobes in slow mode
	logic [3:0] rx_idx;  // position inside the far-end code
	logic       tx_seen; // a tx bit was taken at the last edge
	logic       fire;    // launch a bit this edge

	// slow mode gives one bit in four cycles
	assign fire = run && (!slow || gap_cnt == 2'd3);

	// ==========================================================
	// rx stream: strobe and bit change together, line scrambles between bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_cnt       <= 2'd0;
			rx_idx        <= 4'd0;
			tx_bit_strobe <= 1'b0;
			rx_bit_strobe <= 1'b0;
			tx_data_in    <= 1'b0;
			rx_data_in    <= 1'b0;
		end else begin
			gap_cnt       <= gap_cnt + 2'd1;
			tx_bit_strobe <= fire;
			rx_bit_strobe <= fire;
			if (clr) begin
				rx_idx <= 4'd0;
			end
			if (fire) begin
				// code goes out msb first and wraps at its length
				rx_data_in <= rx_pat[4'd15 - rx_idx];
				tx_data_in <= ~tx_data_in;
				rx_idx     <= ({1'b0, rx_idx} == rx_len - 5'd1) ? 4'd0 : rx_idx + 4'd1;
			end else begin
				// no stale bit may look valid outside a strobe
				rx_data_in <= ~rx_data_in;
			end
		end
	end

	// ==========================================================
	// tx capture one cycle after each strobe, when the bit has landed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_seen   <= 1'b0;
			tx_cap    <= 16'h0000;
			bit_count <= 16'h0000;
		end else begin
			tx_seen <= tx_bit_strobe;
			if (clr) begin
				bit_count <= 16'h0000;
			end else if (tx_bit_strobe) begin
				bit_count <= bit_count + 16'h0001;
			end
			if (tx_seen) begin
				tx_cap <= {tx_cap[14:0], tx_data_out};
			end
		end
	end
endmodule

/* dv/tb_inband_loop_code_engine.sv */
// self-checking bench for the in-band loop code engine
// assumes the package, the design and the line partner are compiled first
`timescale 1ns/100ps
module tb_inband_loop_code_engine
	import inband_pkg::*;
;
	// ==========================================================
	// signals
	localparam logic [15:0] INTEG = 16'd4; // short integration keeps the run brief
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_val;
	logic [3:0]  pstrb;
	logic        tx_bit_strobe, tx_data_in, tx_data_out, rx_bit_strobe, rx_data_in;
	logic        up_detected, down_detected, spare_detected, err_val;
	logic        run, slow, clr;
	logic [15:0] rx_pat, tx_cap, bit_count;
	logic [4:0]  rx_len;
	logic [2:0]  dets;    // detector outputs, up in bit 0
	int          errors, checked, n, k;
	logic [7:0]  map_idx [11] = '{IDX_CTRL, IDX_SPARE_CTRL, IDX_LENGTHS, IDX_TX_HI, IDX_TX_LO,
		IDX_UP_HI, IDX_UP_LO, IDX_DOWN_HI, IDX_DOWN_LO, IDX_SPARE_HI, IDX_SPARE_LO};
	int          tx_len [4] = '{5, 6, 7, 16};
	logic [7:0]  hi_idx [3] = '{IDX_UP_HI, IDX_DOWN_HI, IDX_SPARE_HI};
	logic [7:0]  hi_val [3] = '{8'hDF, 8'hF0, 8'h97}; // low bits beyond length set on purpose
	logic [15:0] det_pat [3] = '{16'hC000, 16'hF00C, 16'h9000};
	logic [4:0]  det_len [3] = '{5'd3, 5'd16, 5'd5};

	assign dets = {spare_detected, down_detected, up_detected};

	inband_loop_code_engine #(.INTEG_BITS(INTEG)) inband_loop_code_engine_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_bit_strobe(tx_bit_strobe), .tx_data_in(tx_data_in),
		.tx_data_out(tx_data_out), .rx_bit_strobe(rx_bit_strobe), .rx_data_in(rx_data_in),
		.up_detected(up_detected), .down_detected(down_detected),
		.spare_detected(spare_detected));

	line_partner line_partner_i (
		.pclk(pclk), .presetn(presetn), .run(run), .slow(slow), .clr(clr), .rx_pat(rx_pat),
		.rx_len(rx_len), .tx_data_out(tx_data_out), .tx_bit_strobe(tx_bit_strobe),
		.tx_data_in(tx_data_in), .rx_bit_strobe(rx_bit_strobe), .rx_data_in(rx_data_in),
		.tx_cap(tx_cap), .bit_count(bit_count));

	// ==========================================================
	// tasks
	// one apb transfer; entered anywhere, launches after the next edge
	task automatic apb_xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no local limit: only the watchdog ends a wait that never sees pready
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		apb_xfer(1'b1, {2'b00, idx}, {24'h000000, d}, rd_val, err_val);
	endtask

	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	task automatic check_flag(input logic got, input logic exp, input string what);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	// read a register and compare both data and error response
	task automatic reg_chk(input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
		apb_xfer(1'b0, {2'b00, idx}, 32'h0, rd_val, err_val);
		check_reg(rd_val, exp, "register read");
		check_flag(err_val, exp_err, "error response");
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// clock and watchdog
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// the tests need about a thousand cycles; far more means a hang
	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		close_out();
	end

	// ==========================================================
	// test sequence
	initial begin
		{presetn, psel, penable, pwrite, run, slow, clr} = 7'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0;
		pstrb   = 4'hF;
		rx_pat  = 16'h0000;
		rx_len  = 5'd1;
		errors  = 0;
		checked = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, readback, spare control with reserved bits zero, unmapped slot
		foreach (map_idx[i]) reg_chk(map_idx[i], 32'h0, 1'b0);
		for (int i = 2; i < 11; i++) begin
			reg_wr(map_idx[i], 8'hA5);
			reg_chk(map_idx[i], 32'h0000_00A5, 1'b0);
		end
		reg_wr(IDX_SPARE_CTRL, 8'h04);
		reg_chk(IDX_SPARE_CTRL, 32'h0000_0004, 1'b0);
		reg_chk(8'hB5, 32'h0, 1'b1);
		// high address bits refuse the access; the aliased register keeps its value
		apb_xfer(1'b1, 10'h1B8, 32'h0000_00FF, rd_val, err_val);
		check_flag(err_val, 1'b1, "alias write refused");
		reg_chk(IDX_TX_LO, 32'h0000_00A5, 1'b0);
		$display("test registers done");
		// transmit code at every length select, ignored bits set to catch leaks
		reg_wr(IDX_TX_HI, 8'hB7);
		reg_wr(IDX_TX_LO, 8'h5A);
		for (int s = 0; s < 4; s++) begin
			reg_wr(IDX_CTRL, 8'h00);
			reg_wr(IDX_LENGTHS, {2'(s), 6'b010111});
			clr <= 1'b1;
			reg_wr(IDX_CTRL, 8'h01);
			clr  <= 1'b0;
			slow <= (s == 3);
			run  <= 1'b1;
			repeat (160) @(posedge pclk);
			run <= 1'b0;
			repeat (4) @(posedge pclk);
			n = bit_count;
			for (int j = 0; j < 16; j++) begin
				k = n - 16 + j;
				check_flag(tx_cap[15-j], tx_pat_bit(k, tx_len[s]), "tx bit");
			end
		end
		$display("test transmit done");
		// each detector in turn; the others must stay quiet
		reg_wr(IDX_CTRL, 8'h00);
		reg_wr(IDX_LENGTHS, 8'h17);
		reg_wr(IDX_UP_LO, 8'hFF);
		reg_wr(IDX_DOWN_LO, 8'h0C);
		reg_wr(IDX_SPARE_LO, 8'hFF);
		for (int c = 0; c < 3; c++) begin
			clr    <= 1'b1;
			rx_pat <= det_pat[c];
			rx_len <= det_len[c];
			slow   <= (c == 1);
			for (int h = 0; h < 3; h++) reg_wr(hi_idx[h], hi_val[h]);
			clr <= 1'b0;
			run <= 1'b1;
			n = 0;
			while (dets[c] !== 1'b1 && n < 400) begin
				n++;
				@(negedge pclk);
			end
			check_flag(dets[c], 1'b1, "code declared");
			check_flag(bit_count >= det_len[c] + INTEG, 1'b1, "integration");
			check_reg({29'h0, dets}, 32'h1 << c, "detector set");
			reg_chk(IDX_CTRL, 32'h1 << (STAT_UP + c), 1'b0);
			reg_wr(hi_idx[c], hi_val[c]);
			@(posedge pclk);
			@(negedge pclk);
			check_flag(dets[c], 1'b0, "restart on write");
			run <= 1'b0;
		end
		$display("test detectors done");
		close_out();
	end

	// expected tx bit k of a code of length len taken from the top of 16'hB75A
	function automatic logic tx_pat_bit(input int kk, input int len);
		logic [15:0] w;
		w = 16'hB75A;
		tx_pat_bit = w[15 - (kk % len)];
	endfunction
endmodule
